// ==== hw/rsm_pkg.sv ====
// Purpose: shared constants and types for the reset source monitor
// Assumes: core_clk at 25 MHz is the system clock of the device
// Notes: the clock-loss count derives from its printed time and the clock period
package rsm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LOSS_TIME_US = 100;
  // least time, so round up to whole cycles
  localparam int unsigned LOSS_CYC = (LOSS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOSS_CNT_W = 12;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LAST = LOSS_CNT_W'(LOSS_CYC - 1);
  localparam int unsigned WDT_DIV = 12;
  localparam logic [3:0] WDT_PRE_LAST = 4'(WDT_DIV - 1);
  localparam int unsigned WDT_W = 8;
  localparam int unsigned RST_HOLD_CYC = 16;
  localparam int unsigned HOLD_W = 5;
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_HOLD_CYC - 1);

  // ---------------------------------------------------------------
  // reset cause register layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CAUSE_W = 8;
  localparam int unsigned CAUSE_LOSS_BIT = 2;
  localparam int unsigned CAUSE_CMP_BIT = 5;
  localparam int unsigned CAUSE_WDT_BIT = 5;
  localparam int unsigned CAUSE_FLASH_BIT = 6;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h00;
  localparam logic LOSS_EN_RST = 1'h0;
  localparam logic CMP_ARM_RST = 1'h0;
  localparam logic WDT_EN_RST = 1'h1;
  localparam int unsigned ADDR_W = 16;

  typedef enum logic [1:0] {
    RSM_RUN = 2'b00,
    RSM_HOLD = 2'b01,
    RSM_WAIT = 2'b10
  } rsm_seq_t;

endpackage

// ==== hw/rsm_clk_loss.sv ====
// Purpose: clock-loss one-shot watching the system clock pin
// Assumes: mon_in is asynchronous to core_clk
// Notes: fires a one-cycle pulse after LOSS_CYC cycles without a level change
`timescale 1ns/100ps
module rsm_clk_loss (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic mon_in,
  input wire logic enable,
  output logic timeout_q
);
  logic s1_q, s2_q, s3_q, level_q;
  logic [rsm_pkg::LOSS_CNT_W-1:0] cnt_q;
  logic change;

  // ---------------------------------------------------------------
  // three-stage synchroniser, change counted once stages 2 and 3 agree
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
      level_q <= 1'h0;
    end else if (ce) begin
      s1_q <= mon_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign change = (s2_q == s3_q) && (s3_q != level_q);

  // ---------------------------------------------------------------
  // stuck-level counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
      timeout_q <= 1'h0;
    end else if (ce) begin
      timeout_q <= 1'h0;
      if (!enable || change) begin
        cnt_q <= '0;
      end else if (cnt_q == rsm_pkg::LOSS_LAST) begin
        cnt_q <= '0;
        timeout_q <= 1'h1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  a_loss_no_fire_off: assert property (@(posedge core_clk) disable iff (srst)
    !enable |=> !timeout_q) else $error("clock-loss fired while disabled");
  a_loss_count_ok: assert property (@(posedge core_clk) disable iff (srst)
    timeout_q |-> $past(cnt_q) == rsm_pkg::LOSS_LAST) else $error("clock-loss fired early");
endmodule

// ==== hw/rsm_watchdog.sv ====
// Purpose: watchdog counting system clock divided by 12
// Assumes: kick, stop and start are one-cycle pulses from the core
// Notes: freezes without losing state while hold is high
`timescale 1ns/100ps
module rsm_watchdog (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic hold,
  input wire logic start,
  input wire logic stop,
  input wire logic kick,
  input wire logic [rsm_pkg::WDT_W-1:0] limit,
  output logic en_q,
  output logic expire_q
);
  logic [3:0] pre_q;
  logic [rsm_pkg::WDT_W-1:0] cnt_q;
  logic tick;

  assign tick = (pre_q == rsm_pkg::WDT_PRE_LAST);

  // ---------------------------------------------------------------
  // enable: always back on after any reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q <= rsm_pkg::WDT_EN_RST;
    end else if (ce) begin
      if (sys_rst) begin
        en_q <= 1'h1;
      end else if (stop) begin
        en_q <= 1'h0;
      end else if (start) begin
        en_q <= 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // prescaler and timeout counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_q <= '0;
      cnt_q <= '0;
      expire_q <= 1'h0;
    end else if (ce) begin
      expire_q <= 1'h0;
      if (sys_rst || kick || !en_q) begin
        pre_q <= '0;
        cnt_q <= '0;
      end else if (!hold) begin
        pre_q <= tick ? 4'h0 : pre_q + 4'h1;
        if (tick) begin
          if (cnt_q == limit) begin
            cnt_q <= '0;
            expire_q <= 1'h1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end
  end

  a_wdt_frozen_low: assert property (@(posedge core_clk) disable iff (srst)
    hold |=> !expire_q) else $error("watchdog expired in low power");
endmodule

// ==== hw/rsm_top.sv ====
// Purpose: gathers internal reset causes into one system reset and records the cause
// Assumes: core_clk is the system clock; mode and flash strobes are on the same clock
// Notes: the block never drives the external reset pin; srst is power-on only
`timescale 1ns/100ps

// Behaviour
// - Clock input stuck high or low beyond 100 us raises a system reset.
// - Cause bit 2 reads 1 after a clock-loss reset, else 0.
// - Writing bit 2 enables or disables the clock-loss detector.
// - Clock-loss reset is off in suspend or sleep; setting returns on exit.
// - Writing 1 to bit 5 arms the comparator reset.
// - Armed comparator holds reset while its output is low.
// - Cause bit 5 reads 1 after a comparator or watchdog reset, else 0.
// - Comparator reset stays live in low power if it is a wake source.
// - Watchdog comes up enabled after every reset, ticking every 12 clocks.
// - Watchdog expiry resets the device and sets cause bit 5.
// - Watchdog reset is off in suspend or sleep; setting returns on exit.
// - Flash write enabled data write above the lock byte resets.
// - Code-space read above the lock byte resets.
// - Branch fetch above the lock byte resets.
// - Flash access forbidden by security settings resets.
// - Flash write or erase with supply monitor off resets.
// - Cause bit 6 is set after a flash error reset.
// - Internal resets never touch the external reset pin.
module rsm_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic system_clock,
  input wire logic suspend_mode,
  input wire logic sleep_mode,
  input wire logic comparator_out,
  input wire logic cmp_wake_en,
  input wire logic cause_wr,
  input wire logic [rsm_pkg::CAUSE_W-1:0] cause_wdata,
  input wire logic wdt_start,
  input wire logic wdt_stop,
  input wire logic wdt_kick,
  input wire logic [rsm_pkg::WDT_W-1:0] wdt_limit,
  input wire logic flash_write_enable,
  input wire logic data_space_move_wr,
  input wire logic code_space_read,
  input wire logic branch_fetch,
  input wire logic [rsm_pkg::ADDR_W-1:0] access_addr,
  input wire logic [rsm_pkg::ADDR_W-1:0] lock_byte_addr,
  input wire logic flash_sec_violation,
  input wire logic flash_wr_erase,
  input wire logic supply_mon_en,
  output logic sys_rst_q,
  output logic [rsm_pkg::CAUSE_W-1:0] reset_cause_register_q,
  output logic clock_loss_en_q,
  output logic cmp_arm_q,
  output logic wdt_en_q
);
  logic low_power;
  logic loss_en_eff;
  logic loss_fire;
  logic wdt_fire;
  logic c1_q, c2_q, c3_q, cmp_level_q;
  logic cmp_req;
  logic above_lock;
  logic flash_err;
  logic any_req;
  logic [rsm_pkg::CAUSE_W-1:0] new_cause;
  rsm_pkg::rsm_seq_t seq_q;
  logic [rsm_pkg::HOLD_W-1:0] hold_q;

  // ---------------------------------------------------------------
  // low-power gating
  // ---------------------------------------------------------------
  assign low_power = suspend_mode | sleep_mode;
  // the stored enable is untouched, so leaving low power restores it
  assign loss_en_eff = clock_loss_en_q & ~low_power;

  // ---------------------------------------------------------------
  // software control of the cause register
  // ---------------------------------------------------------------
  // writes configure, they never clear recorded causes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clock_loss_en_q <= rsm_pkg::LOSS_EN_RST;
    end else if (ce && cause_wr) begin
      clock_loss_en_q <= cause_wdata[rsm_pkg::CAUSE_LOSS_BIT];
    end
  end

  // arming survives internal resets so a low comparator keeps the part held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_arm_q <= rsm_pkg::CMP_ARM_RST;
    end else if (ce && cause_wr) begin
      cmp_arm_q <= cause_wdata[rsm_pkg::CAUSE_CMP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // clock-loss detector and watchdog
  // ---------------------------------------------------------------
  rsm_clk_loss u_loss (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .mon_in(system_clock),
    .enable(loss_en_eff),
    .timeout_q(loss_fire)
  );

  rsm_watchdog u_wdt (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .sys_rst(sys_rst_q),
    .hold(low_power),
    .start(wdt_start),
    .stop(wdt_stop),
    .kick(wdt_kick),
    .limit(wdt_limit),
    .en_q(wdt_en_q),
    .expire_q(wdt_fire)
  );

  // ---------------------------------------------------------------
  // comparator output synchroniser
  // ---------------------------------------------------------------
  // the analogue output chatters near its threshold; a level only counts
  // once two stages agree, which also filters single-cycle glitches
  always_ff @(posedge core_clk) begin
    if (srst) begin
      c1_q <= 1'h1;
      c2_q <= 1'h1;
      c3_q <= 1'h1;
      cmp_level_q <= 1'h1;
    end else if (ce) begin
      c1_q <= comparator_out;
      c2_q <= c1_q;
      c3_q <= c2_q;
      if (c2_q == c3_q) begin
        cmp_level_q <= c3_q;
      end
    end
  end

  // active low; in low power only while it is also a wake source
  assign cmp_req = cmp_arm_q & ~cmp_level_q & (~low_power | cmp_wake_en);

  // ---------------------------------------------------------------
  // flash error detection
  // ---------------------------------------------------------------
  assign above_lock = access_addr > lock_byte_addr;
  assign flash_err = (flash_write_enable & data_space_move_wr & above_lock)
                   | (code_space_read & above_lock)
                   | (branch_fetch & above_lock)
                   | flash_sec_violation
                   | (flash_wr_erase & ~supply_mon_en);

  // ---------------------------------------------------------------
  // cause collection
  // ---------------------------------------------------------------
  always_comb begin
    new_cause = '0;
    new_cause[rsm_pkg::CAUSE_LOSS_BIT] = loss_fire;
    new_cause[rsm_pkg::CAUSE_CMP_BIT] = cmp_req | wdt_fire;
    new_cause[rsm_pkg::CAUSE_FLASH_BIT] = flash_err;
  end

  assign any_req = |new_cause;

  // a fresh reset replaces the old cause; causes during a reset accumulate
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reset_cause_register_q <= rsm_pkg::CAUSE_RST;
    end else if (ce && any_req) begin
      if (seq_q == rsm_pkg::RSM_RUN) begin
        reset_cause_register_q <= new_cause;
      end else begin
        reset_cause_register_q <= reset_cause_register_q | new_cause;
      end
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // sys_rst_q goes only to the core; there is no path to the reset pin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_q <= rsm_pkg::RSM_RUN;
      hold_q <= '0;
      sys_rst_q <= 1'h0;
    end else if (ce) begin
      case (seq_q)
        rsm_pkg::RSM_RUN: begin
          if (any_req) begin
            seq_q <= rsm_pkg::RSM_HOLD;
            hold_q <= rsm_pkg::HOLD_LAST;
            sys_rst_q <= 1'h1;
          end
        end
        rsm_pkg::RSM_HOLD: begin
          if (hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
          end else if (any_req) begin
            seq_q <= rsm_pkg::RSM_WAIT;
          end else begin
            seq_q <= rsm_pkg::RSM_RUN;
            sys_rst_q <= 1'h0;
          end
        end
        rsm_pkg::RSM_WAIT: begin
          if (!any_req) begin
            seq_q <= rsm_pkg::RSM_RUN;
            sys_rst_q <= 1'h0;
          end
        end
        default: begin
          seq_q <= rsm_pkg::RSM_RUN;
          sys_rst_q <= 1'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_take;
    ce && seq_q == rsm_pkg::RSM_RUN && any_req;
  endsequence

  sequence s_held;
    sys_rst_q && seq_q == rsm_pkg::RSM_HOLD && hold_q == rsm_pkg::HOLD_LAST;
  endsequence

  a_hold_start: assert property (s_take |=> s_held)
    else $error("reset not entered with full hold count");
  a_hold_span: assert property (s_take ##1 s_held |-> sys_rst_q[*8] ##1 sys_rst_q[*8])
    else $error("reset released before its minimum hold");
  a_loss_flag: assert property (ce && loss_fire && seq_q == rsm_pkg::RSM_RUN
    |=> sys_rst_q && reset_cause_register_q[rsm_pkg::CAUSE_LOSS_BIT]) else $error("clock-loss flag missing");
  a_loss_clear: assert property (ce && !loss_fire && seq_q == rsm_pkg::RSM_RUN && any_req
    |=> !reset_cause_register_q[rsm_pkg::CAUSE_LOSS_BIT]) else $error("stale clock-loss flag");
  a_enable_write: assert property (ce && cause_wr
    |=> clock_loss_en_q == $past(cause_wdata[rsm_pkg::CAUSE_LOSS_BIT])) else $error("detector enable not written");
  a_loss_restore: assert property (ce && low_power ##1 ce && !low_power && clock_loss_en_q
    |-> loss_en_eff) else $error("clock-loss enable not restored");
  a_cmp_arm: assert property (ce && cause_wr && cause_wdata[rsm_pkg::CAUSE_CMP_BIT]
    |=> cmp_arm_q) else $error("comparator not armed");
  a_cmp_held: assert property (ce && cmp_req |=> sys_rst_q)
    else $error("armed comparator low but no reset");
  a_cmp_flag: assert property (ce && cmp_req && seq_q == rsm_pkg::RSM_RUN
    |=> reset_cause_register_q[rsm_pkg::CAUSE_CMP_BIT]) else $error("comparator flag missing");
  a_cmp_sleep: assert property (cmp_arm_q && !cmp_level_q && low_power && !cmp_wake_en
    |-> !cmp_req) else $error("comparator reset in low power without wake");
  a_wdt_after_rst: assert property (ce && $fell(sys_rst_q) |-> wdt_en_q)
    else $error("watchdog not enabled after reset");
  a_wdt_flag: assert property (ce && wdt_fire && seq_q == rsm_pkg::RSM_RUN
    |=> sys_rst_q && reset_cause_register_q[rsm_pkg::CAUSE_WDT_BIT]) else $error("watchdog flag missing");
  a_flash_lock: assert property (ce && branch_fetch && access_addr > lock_byte_addr
    |=> sys_rst_q) else $error("branch above lock byte not reset");
  a_flash_supply: assert property (ce && flash_wr_erase && !supply_mon_en
    |=> sys_rst_q) else $error("flash write without supply monitor not reset");
  a_flash_flag: assert property (ce && flash_err && seq_q == rsm_pkg::RSM_RUN
    |=> reset_cause_register_q[rsm_pkg::CAUSE_FLASH_BIT]) else $error("flash error flag missing");

  // ---------------------------------------------------------------
  // checks on gating, flash decode and cause keeping
  // ---------------------------------------------------------------
  // gating must reach into the one-shot, not only the local enable
  a_loss_sleep: assert property (ce && low_power |=> !loss_fire)
    else $error("clock-loss fired in low power");

  a_wdt_sleep: assert property (ce && low_power |=> !wdt_fire)
    else $error("watchdog fired in low power");

  a_wdt_rst: assert property (ce && wdt_fire |=> sys_rst_q)
    else $error("watchdog expiry without reset");

  a_wdt_relaunch: assert property (ce && sys_rst_q |=> wdt_en_q)
    else $error("watchdog not enabled during reset");

  a_cmp_wake: assert property (ce && cmp_arm_q && !cmp_level_q && cmp_wake_en |=> sys_rst_q)
    else $error("comparator wake source did not reset");

  a_flash_write: assert property (ce && flash_write_enable && data_space_move_wr && above_lock
    |=> sys_rst_q) else $error("data write above lock byte not reset");

  a_flash_read: assert property (ce && code_space_read && above_lock |=> sys_rst_q)
    else $error("code read above lock byte not reset");

  a_flash_secure: assert property (ce && flash_sec_violation |=> sys_rst_q)
    else $error("forbidden flash access not reset");

  // a write only configures; a recorded cause must survive it
  a_cause_kept: assert property (ce && cause_wr && !any_req
    |=> reset_cause_register_q == $past(reset_cause_register_q)) else $error("cause changed by a write");

  a_flash_late: assert property (ce && flash_err && seq_q != rsm_pkg::RSM_RUN
    |=> reset_cause_register_q[rsm_pkg::CAUSE_FLASH_BIT]) else $error("flash error during reset lost");

  a_wait_held: assert property (ce && seq_q == rsm_pkg::RSM_WAIT && any_req |=> sys_rst_q)
    else $error("reset released with a live request");
endmodule

// ==== verif/rsm_far_model.sv ====
// Purpose: far side of the reset source monitor: monitored clock source and comparator
// Assumes: the bench steers it on core_clk
// Notes: a stopped clock freezes at its last level
`timescale 1ns/100ps
module rsm_far_model (
  input wire logic core_clk,
  input wire logic clk_run,
  input wire logic cmp_low,
  output logic system_clock,
  output logic comparator_out
);
  // ---------------------------------------------------------------
  // monitored clock
  // ---------------------------------------------------------------
  // four core cycles per level, so the sampling stages can agree on it
  logic [2:0] div_q = 3'h0;
  // holding the level when stopped is the case the one-shot must catch
  always @(posedge core_clk) begin
    if (clk_run) begin
      div_q <= div_q + 3'h1;
    end
  end
  assign system_clock = div_q[2];
  // ---------------------------------------------------------------
  // comparator: low output means plus input below minus input
  // ---------------------------------------------------------------
  assign comparator_out = ~cmp_low;
endmodule

// ==== verif/reset_source_monitor_tb_top.sv ====
// Purpose: self-checking bench for the reset source monitor
// Assumes: all causes are stirred through plain ports and the far side model
// Notes: watchdog limit 7 gives expiry after 96 cycles; kicks every 32 keep it quiet
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module reset_source_monitor_tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic system_clock, comparator_out;
  logic suspend_mode = 1'b0;
  logic sleep_mode = 1'b0;
  logic cmp_wake_en = 1'b0;
  logic cause_wr = 1'b0;
  logic [7:0] cause_wdata = 8'h00;
  logic wdt_start = 1'b0;
  logic wdt_stop = 1'b0;
  logic wdt_kick = 1'b0;
  logic flash_write_enable = 1'b1;
  logic supply_mon_en = 1'b0;
  logic data_space_move_wr = 1'b0;
  logic code_space_read = 1'b0;
  logic branch_fetch = 1'b0;
  logic flash_sec_violation = 1'b0;
  logic flash_wr_erase = 1'b0;
  logic [15:0] access_addr = 16'h0000;
  logic sys_rst_q, clock_loss_en_q, cmp_arm_q, wdt_en_q;
  logic [7:0] reset_cause_register_q;
  logic kick_en = 1'b1;
  logic clk_run = 1'b1;
  logic cmp_low = 1'b0;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #20 core_clk = ~core_clk;

  rsm_top DUT (.core_clk(core_clk), .srst(srst), .ce(1'b1), .system_clock(system_clock),
    .suspend_mode(suspend_mode), .sleep_mode(sleep_mode), .comparator_out(comparator_out),
    .cmp_wake_en(cmp_wake_en), .cause_wr(cause_wr), .cause_wdata(cause_wdata), .wdt_start(wdt_start),
    .wdt_stop(wdt_stop), .wdt_kick(wdt_kick), .wdt_limit(8'h07), .flash_write_enable(flash_write_enable),
    .data_space_move_wr(data_space_move_wr), .code_space_read(code_space_read), .branch_fetch(branch_fetch),
    .access_addr(access_addr), .lock_byte_addr(16'h7fff), .flash_sec_violation(flash_sec_violation),
    .flash_wr_erase(flash_wr_erase), .supply_mon_en(supply_mon_en), .sys_rst_q(sys_rst_q),
    .reset_cause_register_q(reset_cause_register_q), .clock_loss_en_q(clock_loss_en_q),
    .cmp_arm_q(cmp_arm_q), .wdt_en_q(wdt_en_q));

  rsm_far_model far (.core_clk(core_clk), .clk_run(clk_run), .cmp_low(cmp_low),
    .system_clock(system_clock), .comparator_out(comparator_out));

  // ---------------------------------------------------------------
  // closing, watchdog service and hang limit
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    wdt_kick <= kick_en && (cyc[4:0] == 5'h00);
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic wr_cause(input logic [7:0] d);
    @(posedge core_clk);
    cause_wr <= 1'b1;
    cause_wdata <= d;
    @(posedge core_clk);
    cause_wr <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wdt_cmd(input logic st, input logic sp);
    @(posedge core_clk);
    wdt_start <= st;
    wdt_stop <= sp;
    @(posedge core_clk);
    wdt_start <= 1'b0;
    wdt_stop <= 1'b0;
    @(negedge core_clk);
  endtask

  // s bits: data move write, code read, branch, security, write or erase
  task automatic strobe(input logic [4:0] s, input logic [15:0] a);
    @(posedge core_clk);
    {flash_wr_erase, flash_sec_violation, branch_fetch, code_space_read, data_space_move_wr} <= s;
    access_addr <= a;
    @(posedge core_clk);
    {flash_wr_erase, flash_sec_violation, branch_fetch, code_space_read, data_space_move_wr} <= 5'h00;
    @(negedge core_clk);
  endtask

  task automatic no_rst(input int n);
    int seen;
    seen = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (sys_rst_q !== 1'b0) seen++;
    end
    `CHK(seen, 0)
  endtask

  task automatic wait_hi(input int lim, input logic [7:0] cause);
    int n;
    n = 0;
    while (sys_rst_q !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(sys_rst_q, 1'b1)
    `CHK(reset_cause_register_q, cause)
  endtask

  // the hold check is skipped where a live comparator request stretched the reset
  task automatic wait_lo(input logic hold_chk);
    int h;
    h = 0;
    while (sys_rst_q === 1'b1 && h < 200) begin
      @(negedge core_clk);
      h++;
    end
    `CHK(sys_rst_q, 1'b0)
    `CHK((h >= rsm_pkg::RST_HOLD_CYC) || !hold_chk, 1'b1)
    `CHK(wdt_en_q, 1'b1)
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    `CHK(sys_rst_q, 1'b0)
    `CHK(reset_cause_register_q, 8'h00)
    `CHK({clock_loss_en_q, cmp_arm_q}, 2'b00)
    `CHK(wdt_en_q, 1'b1)
    for (int k = 0; k < 5; k++) begin
      strobe(5'h01 << k, (k < 3) ? 16'h8000 : 16'h0100);
      wait_hi(10, 8'h40);
      wait_lo(1'b1);
    end
    @(posedge core_clk);
    flash_write_enable <= 1'b0;
    supply_mon_en <= 1'b1;
    strobe(5'h01, 16'h8000);
    no_rst(30);
    strobe(5'h02, 16'h7fff);
    no_rst(30);
    strobe(5'h10, 16'h0100);
    no_rst(30);
    no_rst(300);
    wdt_cmd(1'b0, 1'b1);
    `CHK(wdt_en_q, 1'b0)
    kick_en = 1'b0;
    no_rst(300);
    wdt_cmd(1'b1, 1'b0);
    wait_hi(130, 8'h20);
    wait_lo(1'b1);
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    no_rst(300);
    @(posedge core_clk);
    sleep_mode <= 1'b0;
    wait_hi(130, 8'h20);
    wait_lo(1'b1);
    kick_en = 1'b1;
    wr_cause(8'h04);
    `CHK(clock_loss_en_q, 1'b1)
    @(posedge core_clk);
    suspend_mode <= 1'b1;
    clk_run <= 1'b0;
    no_rst(2700);
    @(posedge core_clk);
    clk_run <= 1'b1;
    @(posedge core_clk);
    suspend_mode <= 1'b0;
    @(negedge core_clk);
    `CHK(clock_loss_en_q, 1'b1)
    no_rst(2700);
    @(posedge core_clk);
    clk_run <= 1'b0;
    no_rst(2400);
    wait_hi(200, 8'h04);
    wait_lo(1'b1);
    @(posedge core_clk);
    clk_run <= 1'b1;
    wr_cause(8'h00);
    `CHK(clock_loss_en_q, 1'b0)
    `CHK(reset_cause_register_q, 8'h04)
    @(posedge core_clk);
    clk_run <= 1'b0;
    no_rst(2700);
    @(posedge core_clk);
    clk_run <= 1'b1;
    // comparator has sat high and settled long before it is armed
    wr_cause(8'h20);
    `CHK(cmp_arm_q, 1'b1)
    @(posedge core_clk);
    cmp_low <= 1'b1;
    wait_hi(10, 8'h20);
    n = 0;
    repeat (40) begin
      @(negedge core_clk);
      if (sys_rst_q === 1'b1) n++;
    end
    `CHK(n, 40)
    @(posedge core_clk);
    cmp_low <= 1'b0;
    wait_lo(1'b0);
    wr_cause(8'h00);
    `CHK(cmp_arm_q, 1'b0)
    `CHK(reset_cause_register_q, 8'h20)
    @(posedge core_clk);
    cmp_low <= 1'b1;
    no_rst(30);
    @(posedge core_clk);
    cmp_low <= 1'b0;
    no_rst(8);
    wr_cause(8'h20);
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    cmp_low <= 1'b1;
    no_rst(30);
    @(posedge core_clk);
    cmp_wake_en <= 1'b1;
    wait_hi(10, 8'h20);
    @(posedge core_clk);
    cmp_low <= 1'b0;
    wait_lo(1'b0);
    @(posedge core_clk);
    sleep_mode <= 1'b0;
    finish_test();
  end
endmodule
